// ==== hdl/dcbr_block_mem.sv ====
// dual clock 256x16 block memory with bit inhibit and configuration preload
`timescale 1ns/10ps
`include "dcbr_consts.svh"
module dcbr_block_mem #(
  parameter bit STORE_FALLING = 1'b0,
  parameter bit FETCH_FALLING = 1'b0
) (
  // system
  input  wire logic                clk_sys_in,
  input  wire logic                rst_in,
  // configuration preload, same clock domain
  input  wire logic                cfg_active_in,
  input  wire logic                cfg_write_in,
  input  wire dcbr_pkg::dcbr_addr_t cfg_addr_in,
  input  wire dcbr_pkg::dcbr_word_t cfg_data_in,
  output logic                     cfg_busy_out,
  // write port pins
  input  wire logic                store_clock_in,
  input  wire logic                store_clock_gate_in,
  input  wire logic                store_enable_in,
  input  wire dcbr_pkg::dcbr_addr_t store_location_in,
  input  wire dcbr_pkg::dcbr_word_t store_data_in,
  input  wire dcbr_pkg::dcbr_word_t store_inhibit_in,
  // read port pins
  input  wire logic                fetch_clock_in,
  input  wire logic                fetch_clock_gate_in,
  input  wire logic                fetch_enable_in,
  input  wire dcbr_pkg::dcbr_addr_t fetch_location_in,
  output dcbr_pkg::dcbr_word_t     fetch_data_out
);
  import dcbr_pkg::*;

  dcbr_word_t  mem [`DCBR_DEPTH];
  dcbr_state_t state_reg;
  dcbr_state_t state_next;
  logic        busy_reg;

  logic        wr_edge_w;
  logic        rd_edge_w;
  logic [`DCBR_WR_BUS_W-1:0] wr_bus_w;
  logic [`DCBR_RD_BUS_W-1:0] rd_bus_w;

  // input registers at the array
  logic        wr_go_reg;
  dcbr_addr_t  wr_addr_reg;
  dcbr_word_t  wr_data_reg;
  dcbr_word_t  wr_mask_reg;
  logic        rd_go_reg;
  dcbr_addr_t  rd_addr_reg;
  dcbr_word_t  fetch_data_reg;

  // each port's pins other than its clock travel to its synchroniser as one bus
  wire [`DCBR_WR_BUS_W-1:0] wr_pins_w = {store_clock_gate_in, store_enable_in,
                                         store_location_in, store_data_in,
                                         store_inhibit_in};
  wire [`DCBR_RD_BUS_W-1:0] rd_pins_w = {fetch_clock_gate_in, fetch_enable_in,
                                         fetch_location_in};

  dcbr_port_sync #(.W(`DCBR_WR_BUS_W), .FALLING(STORE_FALLING)) u_store_sync (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .pin_clock_in (store_clock_in),
    .pin_bus_in   (wr_pins_w),
    .edge_out     (wr_edge_w),
    .bus_out      (wr_bus_w)
  );

  dcbr_port_sync #(.W(`DCBR_RD_BUS_W), .FALLING(FETCH_FALLING)) u_fetch_sync (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .pin_clock_in (fetch_clock_in),
    .pin_bus_in   (rd_pins_w),
    .edge_out     (rd_edge_w),
    .bus_out      (rd_bus_w)
  );

  // field split of the synchronised port buses
  wire         wr_gate_w   = wr_bus_w[`DCBR_WR_GATE_BIT];
  wire         wr_en_w     = wr_bus_w[`DCBR_WR_EN_BIT];
  wire dcbr_addr_t wr_loc_w  = wr_bus_w[`DCBR_WR_LOC_MSB:`DCBR_WR_LOC_LSB];
  wire dcbr_word_t wr_dat_w  = wr_bus_w[`DCBR_WR_DAT_MSB:`DCBR_WR_DAT_LSB];
  wire dcbr_word_t wr_msk_w  = wr_bus_w[`DCBR_WR_MSK_MSB:`DCBR_WR_MSK_LSB];
  wire         rd_gate_w   = rd_bus_w[`DCBR_RD_GATE_BIT];
  wire         rd_en_w     = rd_bus_w[`DCBR_RD_EN_BIT];
  wire dcbr_addr_t rd_loc_w  = rd_bus_w[`DCBR_RD_LOC_MSB:`DCBR_RD_LOC_LSB];

  wire         user_w      = (state_reg == DCBR_ST_USER);
  wire         wr_take_w   = user_w & wr_edge_w & wr_gate_w & wr_en_w;
  wire         rd_take_w   = user_w & rd_edge_w & rd_gate_w & rd_en_w;
  wire         cfg_take_w  = ~user_w & cfg_write_in
                             & (cfg_addr_in != `DCBR_NO_PRELOAD);
  wire dcbr_word_t cur_w   = mem[wr_addr_reg];
  wire dcbr_word_t merge_w;

  // per bit: inhibit 1 keeps the stored bit, 0 takes the new one
  for (genvar b = 0; b < `DCBR_DATA_W; b++) begin : g_merge
    assign merge_w[b] = wr_mask_reg[b] ? cur_w[b] : wr_data_reg[b];
  end

  // preload owns the array write port while configuration lasts
  wire             mem_we_w   = cfg_take_w | wr_go_reg;
  wire dcbr_addr_t mem_addr_w = cfg_take_w ? cfg_addr_in : wr_addr_reg;
  wire dcbr_word_t mem_din_w  = cfg_take_w ? cfg_data_in : merge_w;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DCBR_ST_CONFIG: begin
        if (!cfg_active_in) begin
          state_next = DCBR_ST_USER;
        end
      end
      DCBR_ST_USER: begin
        state_next = DCBR_ST_USER;
      end
      default: begin
        state_next = DCBR_ST_CONFIG;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_reg <= DCBR_ST_CONFIG;
      busy_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      busy_reg  <= (state_next == DCBR_ST_CONFIG);
    end
  end

  // one-cycle strobes that follow a taken port edge
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_go_reg <= 1'b0;
      rd_go_reg <= 1'b0;
    end else begin
      wr_go_reg <= wr_take_w;
      rd_go_reg <= rd_take_w;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_mask_reg <= '0;
    end else begin
      if (wr_take_w) begin
        wr_addr_reg <= wr_loc_w;
        wr_data_reg <= wr_dat_w;
        wr_mask_reg <= wr_msk_w;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rd_addr_reg    <= '0;
      fetch_data_reg <= `DCBR_DATA_RESET;
    end else begin
      if (rd_take_w) begin
        rd_addr_reg <= rd_loc_w;
      end
      if (rd_go_reg) begin
        fetch_data_reg <= mem[rd_addr_reg];
      end
    end
  end

  // array itself has no reset; word 0 powers up undefined
  // a read and a write of one word on the same edge return the old word
  always_ff @(posedge clk_sys_in) begin
    if (mem_we_w) begin
      mem[mem_addr_w] <= mem_din_w;
    end
  end

  assign cfg_busy_out   = busy_reg;
  assign fetch_data_out = fetch_data_reg;
endmodule

// ==== hdl/dcbr_consts.svh ====
// constants for the dual clock 256x16 block memory
// Functional notes
// - an 8-bit store location picks exactly one of 256 words to write
// - an 8-bit fetch location picks exactly one of 256 words to read
// - inhibit bit 0 stores that data bit, inhibit bit 1 keeps the old bit
// - data and addresses of both ports are registered before the array uses them
// - write port samples on rising store clock edge, falling edge by build option
// - read port works on rising fetch clock edge, falling by its own option
// - contents may be preloaded during configuration before user operation
// - word 0 never takes a preload value
// - each block holds 4 kbit of storage
`ifndef DCBR_CONSTS_SVH
`define DCBR_CONSTS_SVH
`define DCBR_ADDR_W      8
`define DCBR_DATA_W      16
`define DCBR_DEPTH       256
`define DCBR_NO_PRELOAD  8'h00
`define DCBR_DATA_RESET  16'h0000
`define DCBR_WR_BUS_W    42
`define DCBR_RD_BUS_W    10
// field positions inside the synchronised write port bus
`define DCBR_WR_GATE_BIT 41
`define DCBR_WR_EN_BIT   40
`define DCBR_WR_LOC_MSB  39
`define DCBR_WR_LOC_LSB  32
`define DCBR_WR_DAT_MSB  31
`define DCBR_WR_DAT_LSB  16
`define DCBR_WR_MSK_MSB  15
`define DCBR_WR_MSK_LSB  0
// field positions inside the synchronised read port bus
`define DCBR_RD_GATE_BIT 9
`define DCBR_RD_EN_BIT   8
`define DCBR_RD_LOC_MSB  7
`define DCBR_RD_LOC_LSB  0
`endif

// ==== hdl/dcbr_pkg.sv ====
// types for the dual clock 256x16 block memory
`include "dcbr_consts.svh"
package dcbr_pkg;
  typedef logic [`DCBR_ADDR_W-1:0] dcbr_addr_t;
  typedef logic [`DCBR_DATA_W-1:0] dcbr_word_t;
  typedef enum logic {DCBR_ST_CONFIG, DCBR_ST_USER} dcbr_state_t;
endpackage

// ==== hdl/dcbr_port_sync.sv ====
// pin synchroniser and selectable edge detector for one memory port
`timescale 1ns/10ps
module dcbr_port_sync #(
  parameter int W       = 1,
  parameter bit FALLING = 1'b0
) (
  // system
  input  wire logic         clk_sys_in,
  input  wire logic         rst_in,
  // pins
  input  wire logic         pin_clock_in,
  input  wire logic [W-1:0] pin_bus_in,
  // synchronised view
  output logic              edge_out,
  output logic [W-1:0]      bus_out
);
  logic [W-1:0] bus_s1_reg;
  logic [W-1:0] bus_s2_reg;
  logic         clk_s1_reg;
  logic         clk_s2_reg;
  logic         clk_s3_reg;
  wire          rise_w = clk_s2_reg & ~clk_s3_reg;
  wire          fall_w = ~clk_s2_reg & clk_s3_reg;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      bus_s1_reg <= '0;
      bus_s2_reg <= '0;
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
    end else begin
      bus_s1_reg <= pin_bus_in;
      bus_s2_reg <= bus_s1_reg;
      clk_s1_reg <= pin_clock_in;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end

  assign edge_out = FALLING ? fall_w : rise_w;
  assign bus_out  = bus_s2_reg;
endmodule

// ==== sim/dcbr_monitor.sv ====
// assertions on the block memory ports
`timescale 1ns/10ps
module dcbr_monitor (
  input wire logic                 clk_sys_in,
  input wire logic                 rst_in,
  input wire logic                 cfg_active_in,
  input wire logic                 cfg_busy_out,
  input wire logic                 fetch_clock_in,
  input wire logic                 fetch_enable_in,
  input wire dcbr_pkg::dcbr_word_t fetch_data_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  chk_busy_reset: assert property (disable iff (1'h0) rst_in |=> cfg_busy_out)
    else $error("busy low");
  chk_data_reset: assert property (disable iff (1'h0)
    rst_in |=> fetch_data_out == 16'h0000) else $error("data set");
  chk_busy_holds: assert property (cfg_busy_out && cfg_active_in |=> cfg_busy_out)
    else $error("busy fell");
  chk_config_ends: assert property (cfg_busy_out && !cfg_active_in
    |-> ##[1:2] !cfg_busy_out) else $error("busy stuck");
  chk_user_final: assert property (!cfg_busy_out |=> !cfg_busy_out)
    else $error("busy rose");
  chk_config_quiet: assert property (cfg_busy_out |-> fetch_data_out == 16'h0000)
    else $error("read in config");
  chk_enable_hold: assert property (!fetch_enable_in [*8] |=> $stable(fetch_data_out))
    else $error("read disabled");
  chk_clock_still: assert property ($stable(fetch_clock_in) [*8]
    |=> $stable(fetch_data_out)) else $error("read no edge");
  cover property ($changed(fetch_data_out));
  cover property ($fell(cfg_busy_out));
  cover property (!cfg_busy_out && !fetch_enable_in [*8]);
endmodule
bind dcbr_block_mem dcbr_monitor dcbr_monitor_i (.clk_sys_in, .rst_in, .cfg_active_in,
  .cfg_busy_out, .fetch_clock_in, .fetch_enable_in, .fetch_data_out);

// ==== sim/dcbr_user_model.sv ====
// fabric user model: pin clock pulses for both ports
`timescale 1ns/10ps
module dcbr_user_model (
  input  wire logic clk_sys_in,
  input  wire logic store_go_in,
  input  wire logic fetch_go_in,
  output logic      store_clock_out,
  output logic      fetch_clock_out
);
  logic [2:0] s_cnt_reg = 3'h0;
  logic [2:0] f_cnt_reg = 3'h0;
  // clocks idle low, four cycles high per transfer
  always_ff @(posedge clk_sys_in) begin
    s_cnt_reg <= store_go_in ? 3'h4 : s_cnt_reg - 3'(s_cnt_reg != 3'h0);
    f_cnt_reg <= fetch_go_in ? 3'h4 : f_cnt_reg - 3'(f_cnt_reg != 3'h0);
  end
  assign store_clock_out = s_cnt_reg != 3'h0;
  assign fetch_clock_out = f_cnt_reg != 3'h0;
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the block memory
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("FAIL %s exp %h got %h", n, e, a); end end
module testbench;
  import dcbr_pkg::*;
  logic clk_sys_in = 1'h0, rst_in = 1'h1, ca = 1'h1, cw = 1'h0, sgo = 1'h0, fgo = 1'h0;
  logic sg = 1'h0, se = 1'h0, fg = 1'h0, fe = 1'h0, cb, cbn, sck, fck;
  dcbr_addr_t cad = 8'h00, sl = 8'h00, fl = 8'h00;
  dcbr_word_t cd = 16'h0000, sd = 16'h0000, si = 16'h0000, fd, fdn;
  int err_count = 0, compares = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  dcbr_user_model dcbr_user_model_i (.clk_sys_in, .store_go_in(sgo), .fetch_go_in(fgo),
    .store_clock_out(sck), .fetch_clock_out(fck));
  dcbr_block_mem dcbr_block_mem_i (.clk_sys_in, .rst_in, .cfg_active_in(ca),
    .cfg_write_in(cw), .cfg_addr_in(cad), .cfg_data_in(cd), .cfg_busy_out(cb),
    .store_clock_in(sck), .store_clock_gate_in(sg), .store_enable_in(se),
    .store_location_in(sl), .store_data_in(sd), .store_inhibit_in(si),
    .fetch_clock_in(fck), .fetch_clock_gate_in(fg), .fetch_enable_in(fe),
    .fetch_location_in(fl), .fetch_data_out(fd));
  // same pins, both ports working on the falling pin clock edge
  if (1'b1) begin : g_fall
    dcbr_block_mem #(.STORE_FALLING(1'b1), .FETCH_FALLING(1'b1)) dcbr_block_mem_i (
      .clk_sys_in, .rst_in, .cfg_active_in(ca), .cfg_write_in(cw), .cfg_addr_in(cad),
      .cfg_data_in(cd), .cfg_busy_out(cbn), .store_clock_in(sck), .store_clock_gate_in(sg),
      .store_enable_in(se), .store_location_in(sl), .store_data_in(sd),
      .store_inhibit_in(si), .fetch_clock_in(fck), .fetch_clock_gate_in(fg),
      .fetch_enable_in(fe), .fetch_location_in(fl), .fetch_data_out(fdn));
  end
  task automatic wr(input dcbr_addr_t a, input dcbr_word_t d, m, input logic g, e);
    sg <= g; se <= e; sl <= a; sd <= d; si <= m;
    repeat (3) @(posedge clk_sys_in);
    sgo <= 1'h1;
    @(posedge clk_sys_in) sgo <= 1'h0;
    repeat (12) @(posedge clk_sys_in);
  endtask
  task automatic rd(input dcbr_addr_t a, input logic g, e);
    fg <= g; fe <= e; fl <= a;
    repeat (3) @(posedge clk_sys_in);
    fgo <= 1'h1;
    @(posedge clk_sys_in) fgo <= 1'h0;
    repeat (12) @(posedge clk_sys_in);
  endtask
  task automatic t_preload;
    cw <= 1'h1; cad <= 8'h00; cd <= 16'hBEEF;
    @(posedge clk_sys_in) cad <= 8'h05; cd <= 16'h1234;
    @(posedge clk_sys_in) cad <= 8'hFF; cd <= 16'hA5C3;
    @(posedge clk_sys_in) cw <= 1'h0;
    rd(8'h05, 1'h1, 1'h1); `CHK("cfg rd", 16'h0000, fd)
    `CHK("busy cfg", 1'h1, cb)
    ca <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    `CHK("busy", 1'h0, cb)
    `CHK("busy fall", 1'h0, cbn)
  endtask
  task automatic t_table;
    rd(8'h05, 1'h1, 1'h1); `CHK("rd", 16'h1234, fd)
    `CHK("rd fall", 16'h1234, fdn)
    rd(8'hFF, 1'h1, 1'h1); `CHK("rd", 16'hA5C3, fd)
    rd(8'h00, 1'h1, 1'h1); `CHK("w0", 1'h0, fd === 16'hBEEF)
  endtask
  task automatic t_mask;
    wr(8'h05, 16'hFFFF, 16'h00FF, 1'h1, 1'h1);
    rd(8'h05, 1'h1, 1'h1); `CHK("inh", 16'hFF34, fd)
    wr(8'h05, 16'h0000, 16'hFFF0, 1'h1, 1'h1);
    wr(8'h00, 16'h0001, 16'h0000, 1'h1, 1'h1);
    rd(8'h05, 1'h1, 1'h1); `CHK("inh", 16'hFF30, fd)
    `CHK("inh fall", 16'hFF30, fdn)
    rd(8'h00, 1'h1, 1'h1); `CHK("lo", 16'h0001, fd)
    `CHK("lo fall", 16'h0001, fdn)
  endtask
  task automatic t_enables;
    wr(8'h05, 16'h0000, 16'h0000, 1'h0, 1'h1);
    wr(8'h05, 16'h0000, 16'h0000, 1'h1, 1'h0);
    rd(8'h05, 1'h1, 1'h1); `CHK("gated", 16'hFF30, fd)
    rd(8'hFF, 1'h0, 1'h1); `CHK("hold", 16'hFF30, fd)
    rd(8'hFF, 1'h1, 1'h0); `CHK("hold", 16'hFF30, fd)
  endtask
  task automatic stop_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    stop_test;
  end
  initial begin
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    @(posedge clk_sys_in);
    t_preload;
    t_table;
    t_mask;
    t_enables;
    stop_test;
  end
endmodule
